/* hdl/cdet_pkg.sv */
// Shared constants for the charger detection link and transceiver ends
package cdet_pkg;
	// Transceiver register addresses
	localparam logic [5:0] FC_ADDR    = 6'h04;
	localparam logic [5:0] IOPM_ADDR  = 6'h3A;
	localparam logic [5:0] DEBUG_ADDR = 6'h15;
	localparam logic [5:0] RID_ADDR   = 6'h36;
	// Function control values
	localparam logic [7:0] FC_RESET   = 8'h41;
	localparam logic [7:0] FC_FS_NODRV = 8'h49;
	localparam logic [7:0] FC_SUSPEND = 8'h01;
	localparam int         FC_SUSPM_BIT = 6;
	// IO and power management
	localparam logic [7:0] IOPM_RESET = 8'h04;
	localparam int         IOPM_DP_BIT = 4;
	localparam int         IOPM_DM_BIT = 5;
	// ID resistance control and status fields
	localparam int         RID_PU_BIT   = 0;
	localparam int         RID_GO_BIT   = 1;
	localparam int         RID_DONE_BIT = 2;
	localparam int         RID_SESS_BIT = 3;
	localparam int         RID_RES_LSB  = 4;
	localparam int         RID_RES_W    = 3;
	localparam int         RID_GND_BIT  = 7;
	// Link command and receive command fields
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ  = 2'h3;
	localparam int         RX_SESS_LSB = 2;
	localparam logic [1:0] RX_SESS_ON  = 2'h3;
	localparam int         LP_INT_BIT  = 3;
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_SE1 = 2'h3;
	// Timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int RID_CONV_NS     = 400;
	localparam int RID_CONV_CYCLES = (RID_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Controller register map (byte offsets)
	localparam logic [3:0] WB_CTRL     = 4'h0;
	localparam logic [3:0] WB_STATUS   = 4'h4;
	localparam logic [3:0] WB_IRQ_STAT = 4'h8;
	localparam logic [3:0] WB_IRQ_MASK = 4'hC;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MEAS_BIT  = 1;
	localparam int CTRL_LPM_BIT   = 2;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_OUT_LSB     = 1;
	localparam int ST_RID_LSB     = 4;
	localparam int ST_LPLINE_LSB  = 8;
	localparam int IRQ_DONE_BIT   = 0;
	localparam int IRQ_PINT_BIT   = 1;
	// Detection outcome
	typedef enum logic [1:0] {
		OUT_NONE    = 2'h0,
		OUT_CHARGER = 2'h1,
		OUT_HOST    = 2'h2
	} cdet_outcome_type;
endpackage

/* hdl/cdet_link_if.sv */
// Link bus between the controller and the transceiver
`timescale 1ns/10ps
`default_nettype none
interface cdet_link_if;
	logic [7:0] lnk_data;
	logic       stp;
	logic [7:0] phy_data;
	logic       dir;
	logic       nxt;
	modport phy (input lnk_data, input stp, output phy_data, output dir, output nxt);
	modport link (output lnk_data, output stp, input phy_data, input dir, input nxt);
endinterface
`default_nettype wire

/* hdl/cdet_reg_port.sv */
// Link side register access engine with receive command capture
`timescale 1ns/10ps
`default_nettype none
module cdet_reg_port (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic       we_i,
	input  wire logic [5:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       lpm_i,
	input  wire logic       stp_req_i,
	input  wire logic       dir_i,
	input  wire logic       nxt_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      data_o,
	output logic            stp_o,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o
);
	typedef enum logic [6:0] {
		P_IDLE = 7'h01, P_CMD = 7'h02, P_WDAT = 7'h04, P_STP = 7'h08,
		P_RWAIT = 7'h10, P_RGET = 7'h20, P_RXGET = 7'h40
	} cdet_port_type;
	cdet_port_type st_q;
	logic          pend_q;

	// Bus sequencer; a receive command started before the accept preempts our command
	always_ff @(posedge clk_i) begin
		done_o     <= 1'b0;
		rx_valid_o <= 1'b0;
		if (rst_i) begin
			st_q    <= P_IDLE;
			pend_q  <= 1'b0;
			data_o  <= 8'h00;
			stp_o   <= 1'b0;
			rdata_o <= 8'h00;
			rx_data_o <= 8'h00;
		end else begin
			stp_o <= stp_req_i;
			if (req_i)
				pend_q <= 1'b1;
			unique case (st_q)
				P_IDLE: begin
					if (dir_i && !lpm_i)
						st_q <= P_RXGET;
					else if ((req_i || pend_q) && !dir_i) begin
						data_o <= {we_i ? cdet_pkg::CMD_WRITE : cdet_pkg::CMD_READ, addr_i};
						st_q   <= P_CMD;
					end
				end
				P_CMD: begin
					if (dir_i) begin
						data_o <= 8'h00;
						st_q   <= P_RXGET;
					end else if (nxt_i) begin
						data_o <= we_i ? wdata_i : 8'h00;
						st_q   <= we_i ? P_WDAT : P_RWAIT;
					end
				end
				P_WDAT: begin
					if (nxt_i) begin
						data_o <= 8'h00;
						stp_o  <= 1'b1;
						st_q   <= P_STP;
					end
				end
				P_STP: begin
					pend_q <= 1'b0;
					done_o <= 1'b1;
					st_q   <= P_IDLE;
				end
				P_RWAIT: begin
					if (dir_i)
						st_q <= P_RGET;
				end
				P_RGET: begin
					rdata_o <= data_i;
					pend_q  <= 1'b0;
					done_o  <= 1'b1;
					st_q    <= P_IDLE;
				end
				P_RXGET: begin
					rx_data_o  <= data_i;
					rx_valid_o <= 1'b1;
					st_q       <= P_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* hdl/cdet_phy.sv */
// Transceiver end: register access, receive commands, low power and charger pull-ups
`timescale 1ns/10ps
`default_nettype none
module cdet_phy (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	cdet_link_if.phy        lnk,
	input  wire logic [1:0] line_state_i,
	input  wire logic       session_valid_i,
	input  wire logic       id_grounded_i,
	input  wire logic [2:0] id_result_i,
	output logic [7:0]      function_control_o,
	output logic            charger_pullup_plus_line_o,
	output logic            charger_pullup_minus_line_o,
	output logic            id_line_pullup_enable_o,
	output logic            low_power_o
);
	typedef enum logic [10:0] {
		D_IDLE = 11'h001, D_WACK = 11'h002, D_WDAT = 11'h004, D_WEND = 11'h008,
		D_WSTP = 11'h010, D_RACK = 11'h020, D_RTURN = 11'h040, D_RDAT = 11'h080,
		D_RXT = 11'h100, D_RXD = 11'h200, D_LPM = 11'h400
	} cdet_phy_st_type;
	cdet_phy_st_type st_q;
	logic [5:0]  addr_q;
	logic [7:0]  iopm_q;
	logic [2:0]  sent_q;
	logic        int_q;
	logic [1:0]  last_q;
	logic        done_q;
	logic [2:0]  res_q;
	logic [$clog2(cdet_pkg::RID_CONV_CYCLES+1)-1:0] conv_q;
	logic [7:0]  rdval;
	logic        wr_en;
	logic        lp_exit;

	assign wr_en   = (st_q == D_WDAT);
	assign lp_exit = (st_q == D_LPM) && lnk.stp;

	// Register file; the two charger pull-ups are separate bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			function_control_o <= cdet_pkg::FC_RESET;
			iopm_q             <= cdet_pkg::IOPM_RESET;
			id_line_pullup_enable_o <= 1'b0;
		end else begin
			if (wr_en && addr_q == cdet_pkg::FC_ADDR)
				function_control_o <= lnk.lnk_data; // R6
			if (wr_en && addr_q == cdet_pkg::IOPM_ADDR)
				iopm_q <= lnk.lnk_data; // R8
			if (wr_en && addr_q == cdet_pkg::RID_ADDR)
				id_line_pullup_enable_o <= lnk.lnk_data[cdet_pkg::RID_PU_BIT];
			if (lp_exit)
				function_control_o[cdet_pkg::FC_SUSPM_BIT] <= 1'b1; // R5
		end
	end

	// Pull-up enables follow the register bits one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			charger_pullup_plus_line_o  <= 1'b0;
			charger_pullup_minus_line_o <= 1'b0;
			low_power_o                 <= 1'b0;
		end else begin
			charger_pullup_plus_line_o  <= iopm_q[cdet_pkg::IOPM_DP_BIT]; // R7 R14
			charger_pullup_minus_line_o <= iopm_q[cdet_pkg::IOPM_DM_BIT]; // R15 R14
			low_power_o                 <= (st_q == D_LPM);
		end
	end

	// ID resistance conversion; a new start clears the finished flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_q <= '0;
			done_q <= 1'b0;
			res_q  <= 3'h0;
		end else if (wr_en && addr_q == cdet_pkg::RID_ADDR && lnk.lnk_data[cdet_pkg::RID_GO_BIT]) begin
			conv_q <= ($clog2(cdet_pkg::RID_CONV_CYCLES+1))'(cdet_pkg::RID_CONV_CYCLES);
			done_q <= 1'b0;
		end else if (conv_q == 1) begin
			conv_q <= '0;
			done_q <= 1'b1;
			res_q  <= id_result_i;
		end else if (conv_q != 0)
			conv_q <= conv_q - 1'b1;
	end

	// Wake indication in low power; a change wins over the exit clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_q  <= 1'b0;
			last_q <= 2'h0;
		end else begin
			last_q <= {session_valid_i, id_grounded_i};
			if ((st_q == D_LPM) && (last_q != {session_valid_i, id_grounded_i}))
				int_q <= 1'b1;
			else if (lp_exit)
				int_q <= 1'b0;
		end
	end

	// Read data selection; unmapped addresses read zero
	always_comb begin
		rdval = 8'h00;
		unique case (addr_q)
			cdet_pkg::FC_ADDR:    rdval = function_control_o;
			cdet_pkg::IOPM_ADDR:  rdval = iopm_q;
			cdet_pkg::DEBUG_ADDR: rdval = {6'h00, line_state_i};
			cdet_pkg::RID_ADDR: begin
				rdval[cdet_pkg::RID_GND_BIT]  = id_grounded_i;
				rdval[cdet_pkg::RID_RES_LSB +: cdet_pkg::RID_RES_W] = res_q;
				rdval[cdet_pkg::RID_SESS_BIT] = session_valid_i;
				rdval[cdet_pkg::RID_DONE_BIT] = done_q;
				rdval[cdet_pkg::RID_PU_BIT]   = id_line_pullup_enable_o;
			end
			default: rdval = 8'h00;
		endcase
	end

	// Bus sequencer: link commands first, then low power, then receive commands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= D_IDLE;
			addr_q <= 6'h00;
			sent_q <= 3'h0;
			lnk.dir      <= 1'b0;
			lnk.nxt      <= 1'b0;
			lnk.phy_data <= 8'h00;
		end else begin
			unique case (st_q)
				D_IDLE: begin
					if (lnk.lnk_data[7:6] == cdet_pkg::CMD_WRITE || lnk.lnk_data[7:6] == cdet_pkg::CMD_READ) begin
						addr_q  <= lnk.lnk_data[5:0];
						lnk.nxt <= 1'b1;
						st_q    <= (lnk.lnk_data[7:6] == cdet_pkg::CMD_WRITE) ? D_WACK : D_RACK;
					end else if (!function_control_o[cdet_pkg::FC_SUSPM_BIT]) begin
						lnk.dir <= 1'b1;
						st_q    <= D_LPM;
					end else if (sent_q != {session_valid_i, line_state_i}) begin
						sent_q  <= {session_valid_i, line_state_i};
						lnk.dir <= 1'b1;
						st_q    <= D_RXT;
					end
				end
				D_WACK: begin lnk.nxt <= 1'b0; st_q <= D_WDAT; end
				D_WDAT: begin lnk.nxt <= 1'b1; st_q <= D_WEND; end
				D_WEND: begin lnk.nxt <= 1'b0; st_q <= D_WSTP; end
				D_WSTP: if (lnk.stp) st_q <= D_IDLE;
				D_RACK: begin lnk.nxt <= 1'b0; lnk.dir <= 1'b1; st_q <= D_RTURN; end
				D_RTURN: begin lnk.phy_data <= rdval; st_q <= D_RDAT; end
				D_RDAT, D_RXD: begin lnk.dir <= 1'b0; lnk.phy_data <= 8'h00; st_q <= D_IDLE; end
				D_RXT: begin
					lnk.phy_data <= {4'h0, sent_q[2] ? cdet_pkg::RX_SESS_ON : 2'h0, sent_q[1:0]};
					st_q <= D_RXD;
				end
				D_LPM: begin
					// Line state on bits 1:0, wake indication on bit 3
					lnk.phy_data <= {4'h0, int_q, 1'b0, line_state_i};
					if (lnk.stp) begin
						lnk.dir      <= 1'b0;
						lnk.phy_data <= 8'h00;
						st_q         <= D_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* hdl/cdet_link.sv */
// Link end: charger detection sequencer with a Wishbone register slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: ID check: ground, pull-up, start, done, read
// R2: ID result code reported for charger signature
// R3: Synchronous mode: session valid from receive command
// R4: Low power: watch data bit 3 wake
// R5: On wake, exit low power, read cause
// R6: Write 49h to function control first
// R7: Bit 4 of IO register enables DP pull-up
// R8: DP and DM pull-ups separately enabled
// R9: Synchronous line state via debug register read
// R10: Low power line state from data bits 1:0
// R11: Session, FS non-driving, DP then DM pull-up
// R12: Both pull-ups, SE1 means charger
// R13: Both pull-ups, SE0 means host
// R14: Pull-up bit connects data line pull-up
// R15: DM pull-up is bit 5 there
// R16: Report outcome and ID result to software
module cdet_link (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	cdet_link_if.link        lnk,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o
);
	typedef enum logic [14:0] {
		S_IDLE = 15'h0001, S_IDWAIT = 15'h0002, S_IDPU = 15'h0004, S_IDGO = 15'h0008,
		S_IDPOLL = 15'h0010, S_LPENTER = 15'h0020, S_LPWAIT = 15'h0040, S_LPEXIT = 15'h0080,
		S_CAUSE = 15'h0100, S_SESS = 15'h0200, S_FSMODE = 15'h0400, S_PUDP = 15'h0800,
		S_PUDM = 15'h1000, S_LINE = 15'h2000, S_DONE = 15'h4000
	} cdet_seq_type;
	cdet_seq_type st_q;
	logic        meas_q;
	logic        lpmode_q;
	logic        start_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	cdet_pkg::cdet_outcome_type outcome_q;
	logic [2:0]  rid_q;
	logic [1:0]  lp_line_q;
	logic        sess_q;
	logic        lpm_q;
	logic        issued_q;
	logic        req_q;
	logic        acc_want;
	logic        acc_we;
	logic [5:0]  acc_addr;
	logic [7:0]  acc_wdata;
	logic        done;
	logic [7:0]  rdata;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        wb_wr;
	logic        ev_done;
	logic        ev_pint;
	logic [31:0] status;

	assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign ev_done = (st_q == S_DONE);
	assign ev_pint = (st_q == S_LPWAIT) && lnk.dir && lnk.phy_data[cdet_pkg::LP_INT_BIT];
	// Busy 0, outcome 2:1, ID result 6:4, low-power line state 9:8
	assign status  = {22'h0, lp_line_q, 1'b0, rid_q, 1'b0, outcome_q, st_q != S_IDLE};

	cdet_reg_port u_port (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.req_i      (req_q),
		.we_i       (acc_we),
		.addr_i     (acc_addr),
		.wdata_i    (acc_wdata),
		.lpm_i      (lpm_q),
		.stp_req_i  (st_q == S_LPEXIT),
		.dir_i      (lnk.dir),
		.nxt_i      (lnk.nxt),
		.data_i     (lnk.phy_data),
		.data_o     (lnk.lnk_data),
		.stp_o      (lnk.stp),
		.done_o     (done),
		.rdata_o    (rdata),
		.rx_valid_o (rx_valid),
		.rx_data_o  (rx_data)
	);

	// Transceiver access wanted in each step
	always_comb begin
		acc_want  = 1'b1;
		acc_we    = 1'b1;
		acc_addr  = cdet_pkg::RID_ADDR;
		acc_wdata = 8'h00;
		unique case (st_q)
			S_IDWAIT, S_IDPOLL, S_CAUSE: acc_we = 1'b0; // R1
			S_IDPU: acc_wdata = 8'h01 << cdet_pkg::RID_PU_BIT; // R1
			S_IDGO: acc_wdata = (8'h01 << cdet_pkg::RID_PU_BIT) | (8'h01 << cdet_pkg::RID_GO_BIT); // R1
			S_LPENTER: begin acc_addr = cdet_pkg::FC_ADDR; acc_wdata = cdet_pkg::FC_SUSPEND; end
			S_FSMODE: begin acc_addr = cdet_pkg::FC_ADDR; acc_wdata = cdet_pkg::FC_FS_NODRV; end // R6 R11
			S_PUDP: begin
				acc_addr  = cdet_pkg::IOPM_ADDR;
				acc_wdata = cdet_pkg::IOPM_RESET | (8'h01 << cdet_pkg::IOPM_DP_BIT); // R7 R11
			end
			S_PUDM: begin
				acc_addr  = cdet_pkg::IOPM_ADDR;
				acc_wdata = cdet_pkg::IOPM_RESET | (8'h01 << cdet_pkg::IOPM_DP_BIT)
					| (8'h01 << cdet_pkg::IOPM_DM_BIT); // R15 R11
			end
			S_LINE: begin acc_we = 1'b0; acc_addr = cdet_pkg::DEBUG_ADDR; end // R9
			default: acc_want = 1'b0;
		endcase
	end

	// One request at a time, held off until the previous answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_q    <= 1'b0;
			issued_q <= 1'b0;
		end else begin
			req_q <= acc_want && !issued_q;
			if (done)
				issued_q <= 1'b0;
			else if (acc_want)
				issued_q <= 1'b1;
		end
	end

	// Session valid seen in receive commands
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sess_q <= 1'b0;
		else if (rx_valid)
			sess_q <= (rx_data[cdet_pkg::RX_SESS_LSB +: 2] == cdet_pkg::RX_SESS_ON); // R3
	end

	// Detection sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q      <= S_IDLE;
			outcome_q <= cdet_pkg::OUT_NONE;
			rid_q     <= 3'h0;
			lp_line_q <= 2'h0;
			lpm_q     <= 1'b0;
		end else begin
			unique case (st_q)
				S_IDLE: if (start_q) begin
					outcome_q <= cdet_pkg::OUT_NONE;
					st_q <= meas_q ? S_IDWAIT : (lpmode_q ? S_LPENTER : S_SESS);
				end
				S_IDWAIT: if (done && rdata[cdet_pkg::RID_GND_BIT]) st_q <= S_IDPU; // R1
				S_IDPU: if (done) st_q <= S_IDGO;
				S_IDGO: if (done) st_q <= S_IDPOLL;
				S_IDPOLL: if (done && rdata[cdet_pkg::RID_DONE_BIT]) begin
					rid_q <= rdata[cdet_pkg::RID_RES_LSB +: cdet_pkg::RID_RES_W]; // R1 R2
					st_q  <= lpmode_q ? S_LPENTER : S_SESS;
				end
				S_LPENTER: begin
					lpm_q <= 1'b1; // Keeps the engine off the turned bus
					if (done) st_q <= S_LPWAIT;
				end
				S_LPWAIT: if (lnk.dir) begin
					lp_line_q <= lnk.phy_data[1:0]; // R10
					if (lnk.phy_data[cdet_pkg::LP_INT_BIT]) st_q <= S_LPEXIT; // R4
				end
				S_LPEXIT: if (!lnk.dir) begin // R5
					lpm_q <= 1'b0;
					st_q  <= S_CAUSE;
				end
				S_CAUSE: if (done) st_q <= rdata[cdet_pkg::RID_SESS_BIT] ? S_FSMODE : S_LPENTER; // R5
				S_SESS: if (sess_q) st_q <= S_FSMODE; // R3 R11
				S_FSMODE: if (done) st_q <= S_PUDP;
				S_PUDP: if (done) st_q <= S_PUDM;
				S_PUDM: if (done) st_q <= S_LINE;
				S_LINE: if (done) begin
					if (rdata[1:0] == cdet_pkg::LINE_SE1)
						outcome_q <= cdet_pkg::OUT_CHARGER; // R12
					else if (rdata[1:0] == cdet_pkg::LINE_SE0)
						outcome_q <= cdet_pkg::OUT_HOST; // R13
					st_q <= S_DONE;
				end
				S_DONE: st_q <= S_IDLE; // R16
			endcase
		end
	end

	// Control, mask and sticky status; an event wins over its clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_q    <= 1'b0;
			meas_q     <= 1'b0;
			lpmode_q   <= 1'b0;
			irq_mask_q <= 2'h0;
			irq_stat_q <= 2'h0;
		end else begin
			start_q <= wb_wr && wb_adr_i == cdet_pkg::WB_CTRL && wb_dat_i[cdet_pkg::CTRL_START_BIT];
			if (wb_wr && wb_adr_i == cdet_pkg::WB_CTRL) begin
				meas_q   <= wb_dat_i[cdet_pkg::CTRL_MEAS_BIT];
				lpmode_q <= wb_dat_i[cdet_pkg::CTRL_LPM_BIT];
			end
			if (wb_wr && wb_adr_i == cdet_pkg::WB_IRQ_MASK)
				irq_mask_q <= wb_dat_i[1:0];
			irq_stat_q <= (irq_stat_q & ~((wb_wr && wb_adr_i == cdet_pkg::WB_IRQ_STAT) ? wb_dat_i[1:0] : 2'h0))
				| {ev_pint, ev_done}; // R16
		end
	end

	// Bus answer one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o    <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			irq_o    <= |(irq_stat_q & irq_mask_q);
			unique case (wb_adr_i)
				cdet_pkg::WB_CTRL:     wb_dat_o <= {29'h0, lpmode_q, meas_q, 1'b0};
				cdet_pkg::WB_STATUS:   wb_dat_o <= status; // R16
				cdet_pkg::WB_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_q};
				cdet_pkg::WB_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask_q};
				default:               wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* verif/cdet_assertions.sv */
// Link bus protocol checks between the controller and transceiver ends
`timescale 1ns/10ps
`default_nettype none
module cdet_assertions (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] lnk_data,
	input  wire logic       stp,
	input  wire logic [7:0] phy_data,
	input  wire logic       dir,
	input  wire logic       nxt
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Read turnaround: transceiver owns the bus two cycles, then lets go
	sequence s_read_turn;
		dir ##1 dir ##1 !dir;
	endsequence

	// Write tail: a one-cycle stop carrying an empty byte
	sequence s_write_stop;
		(stp && lnk_data == 8'h00) ##1 !stp;
	endsequence

	// Accept strobes are single pulses and only on an idle bus
	a_nxt_single_pulse: assert property (nxt |=> !nxt) else $error("accept held past one cycle");
	a_nxt_bus_idle: assert property (nxt |-> !dir && !stp) else $error("accept while bus busy");

	// A fresh command is answered within two cycles unless the transceiver grabs the bus
	a_cmd_accepted: assert property ($rose(lnk_data[7]) && !dir |-> ##[1:2] (nxt || dir))
		else $error("command not accepted");
	a_cmd_held: assert property ($rose(lnk_data[7]) && !dir |=> $stable(lnk_data) || dir)
		else $error("command dropped before accept");

	// Second accept of a write ends in the stop cycle
	a_write_stop_tail: assert property (nxt && $past(nxt, 2) |=> s_write_stop)
		else $error("write not closed by stop");
	a_read_turn_seq: assert property (nxt && lnk_data[7:6] == cdet_pkg::CMD_READ |=> s_read_turn)
		else $error("read turnaround wrong");

	// Status bytes: upper nibble empty, bit 2 never set without bit 3
	a_rx_byte_form: assert property (dir && $past(dir) && !$past(nxt, 2)
		|-> phy_data[7:4] == 4'h0 && !(phy_data[2] && !phy_data[3]))
		else $error("status byte malformed");

	// Stop in low power hands the bus back quickly
	a_stop_ends_lp: assert property (dir && stp |-> ##[1:3] !dir) else $error("low power not left");
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the charger detection link and transceiver pair
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb_top;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic        wb_cyc  = 1'b0;
	logic        wb_stb  = 1'b0;
	logic        wb_we   = 1'b0;
	logic [3:0]  wb_adr  = 4'h0;
	logic [3:0]  wb_sel  = 4'hF;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        irq;
	logic [1:0]  line    = 2'h0;
	logic        sess    = 1'b0;
	logic        idg     = 1'b0;
	logic [2:0]  idres   = 3'h0;
	logic [7:0]  fc;
	logic        pu_p;
	logic        pu_m;
	logic        lp;
	logic        idpu;
	logic [31:0] q;
	logic [31:0] seed;
	int          errors  = 0;
	int          checked = 0;

	// Free-running 125 MHz clock
	always #4 clk_i = ~clk_i;

	cdet_link_if lnk();
	cdet_phy cdet_phy_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .line_state_i(line),
		.session_valid_i(sess), .id_grounded_i(idg), .id_result_i(idres), .function_control_o(fc),
		.charger_pullup_plus_line_o(pu_p), .charger_pullup_minus_line_o(pu_m),
		.id_line_pullup_enable_o(idpu), .low_power_o(lp));
	cdet_link cdet_link_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq));
	cdet_assertions cdet_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk_data(lnk.lnk_data),
		.stp(lnk.stp), .phy_data(lnk.phy_data), .dir(lnk.dir), .nxt(lnk.nxt));

	// Minus-line pull-up must never lead the plus-line one
	always @(posedge clk_i) begin
		if (!rst_i && pu_m === 1'b1) `CHK(pu_p, 1'b1)
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Only the two single-ended states give a verdict
	function automatic logic [1:0] exp_out(input logic [1:0] l);
		return (l == 2'h3) ? cdet_pkg::OUT_CHARGER : (l == 2'h0) ? cdet_pkg::OUT_HOST : cdet_pkg::OUT_NONE;
	endfunction

	// One classic cycle; a dead slave is caught by the watchdog
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task end_sim;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog sized well beyond twelve detection runs
	initial begin
		repeat (40000) @(posedge clk_i);
		errors++;
		end_sim;
	end

	// Main sequence: all four line states first, then random ones
	initial begin
		int n;
		logic lpm;
		logic meas;
		logic [1:0] mask;
		seed = 32'hF7852C26;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, cdet_pkg::WB_STATUS, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			lpm = i[0];
			meas = seed[4];
			mask = seed[6:5];
			line <= (i < 4) ? i[1:0] : seed[1:0];
			idres <= seed[9:7];
			sess <= 1'b0;
			idg <= 1'b0;
			rst_i <= 1'b1;
			@(posedge clk_i);
			rst_i <= 1'b0;
			wb(1'b1, cdet_pkg::WB_IRQ_MASK, {30'h0, mask});
			`CHK(fc, cdet_pkg::FC_RESET)
			`CHK({pu_m, pu_p}, 2'h0)
			wb(1'b1, cdet_pkg::WB_CTRL, {29'h0, lpm, meas, 1'b1});
			repeat (20) @(posedge clk_i);
			idg <= meas;
			if (lpm) begin
				n = 0;
				while (lp !== 1'b1 && n < 300) begin
					@(posedge clk_i);
					n++;
				end
				`CHK(lp, 1'b1)
			end
			sess <= 1'b1;
			n = 0;
			do begin
				wb(1'b0, cdet_pkg::WB_STATUS, 32'h0);
				n++;
			end while (q[0] !== 1'b0 && n < 300);
			if (n >= 300) errors++;
			`CHK(q[2:1], exp_out(line))
			if (meas) `CHK(q[6:4], idres)
			if (lpm) `CHK(q[9:8], line)
			`CHK(idpu, meas)
			`CHK(fc, cdet_pkg::FC_FS_NODRV)
			`CHK({pu_m, pu_p, lp}, 3'b110)
			wb(1'b0, cdet_pkg::WB_IRQ_STAT, 32'h0);
			`CHK(q[1:0], {lpm, 1'b1})
			`CHK(irq, |({lpm, 1'b1} & mask))
			wb(1'b1, cdet_pkg::WB_IRQ_STAT, 32'h3);
			wb(1'b0, cdet_pkg::WB_IRQ_STAT, 32'h0);
			`CHK(q[1:0], 2'h0)
			`CHK(irq, 1'b0)
		end
		end_sim;
	end
endmodule
`default_nettype wire
